//--- include/cjx_pkg.sv
/*
 * Constants, types and opcode decode helpers shared by the compare-and-jump and
 * clear-accumulator execution logic.
 * Assumes an 8-bit core with a 16-bit program counter and one system clock.
 */
package cjx_pkg;

    localparam int          DATA_W        = 8;
    localparam int          PC_W          = 16;
    localparam int          FLAG_W        = 7;
    localparam int          SEL_W         = 3;

    // opcode patterns and the masks that pick the fixed bits
    localparam logic [7:0]  OPC_CMPJ_REG  = 8'hB8;
    localparam logic [7:0]  MSK_CMPJ_REG  = 8'hF8;
    localparam logic [7:0]  OPC_CMPJ_IND  = 8'hB6;
    localparam logic [7:0]  MSK_CMPJ_IND  = 8'hFE;
    localparam logic [7:0]  OPC_CLEAR_ACC = 8'hE4;

    localparam logic [PC_W-1:0]   CMPJ_LEN     = 16'h0003;
    localparam int                CMPJ_CYCLES  = 2;
    localparam int                CLEAR_CYCLES = 1;
    localparam logic [DATA_W-1:0] ACC_CLEAR    = 8'h00;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_OPERAND
    } cjx_state_e;

    function automatic logic isCmpjReg(input logic [7:0] opc);
        return (opc & MSK_CMPJ_REG) == OPC_CMPJ_REG;
    endfunction

    function automatic logic isCmpjInd(input logic [7:0] opc);
        return (opc & MSK_CMPJ_IND) == OPC_CMPJ_IND;
    endfunction

    function automatic logic isClearAcc(input logic [7:0] opc);
        return opc == OPC_CLEAR_ACC;
    endfunction

    function automatic logic [PC_W-1:0] relExt(input logic [DATA_W-1:0] rel);
        return {{(PC_W-DATA_W){rel[DATA_W-1]}}, rel};
    endfunction

endpackage

//--- logic/cjx_cmp_branch.sv
/*
 * Unsigned byte compare and relative branch target for compare-and-jump.
 * Purely combinational; the caller registers the results.
 */
`timescale 1ns/1ps
`default_nettype none

module cjx_cmp_branch
    import cjx_pkg::*;
(
    input  wire logic [DATA_W-1:0] lhs,
    input  wire logic [DATA_W-1:0] rhs,
    input  wire logic [PC_W-1:0]   pcBase,
    input  wire logic [DATA_W-1:0] relOffset,
    output logic                   notEqual,
    output logic                   lessThan,
    output logic [PC_W-1:0]        pcFinal
);

    logic [PC_W-1:0] pcNext;

    always_comb
    begin
        pcNext   = pcBase + CMPJ_LEN;
        notEqual = lhs != rhs;
        lessThan = lhs < rhs;
        // displacement counts from the following instruction
        pcFinal  = notEqual ? pcNext + relExt(relOffset) : pcNext;
    end

endmodule

`default_nettype wire

//--- logic/cjx_exec.sv
/*
 * Execution of compare-and-jump-if-not-equal (working register or indirect RAM
 * byte against immediate) and of clear-accumulator.
 * Assumes the core presents the operand byte selected by operandSel_q and
 * operandIsRam_q during the cycle after issue, and applies the write strobes.
 */
`timescale 1ns/1ps
`default_nettype none

module cjx_exec
    import cjx_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              issueValid,
    input  wire logic [7:0]        opcode,
    input  wire logic [DATA_W-1:0] immData,
    input  wire logic [DATA_W-1:0] relOffset,
    input  wire logic [PC_W-1:0]   pcIn,
    input  wire logic              carryIn,
    input  wire logic [FLAG_W-1:0] flagsIn,
    input  wire logic [DATA_W-1:0] operandData,
    output logic                   busy_q,
    output logic                   done_q,
    output logic [SEL_W-1:0]       operandSel_q,
    output logic                   operandIsRam_q,
    output logic                   pcWrite_q,
    output logic [PC_W-1:0]        pcOut_q,
    output logic                   accWrite_q,
    output logic [DATA_W-1:0]      accOut_q,
    output logic                   carryOut_q,
    output logic [FLAG_W-1:0]      flagsOut_q
);

    typedef struct packed {
        cjx_state_e        state;
        logic              busy;
        logic              done;
        logic [SEL_W-1:0]  opSel;
        logic              opIsRam;
        logic              pcWrite;
        logic [PC_W-1:0]   pc;
        logic [DATA_W-1:0] imm;
        logic [DATA_W-1:0] rel;
        logic              accWrite;
        logic [DATA_W-1:0] acc;
        logic              carry;
        logic [FLAG_W-1:0] flags;
    } cjx_state_s;

    localparam cjx_state_s ST_RESET = '0;

    cjx_state_s      st_q;
    cjx_state_s      st_d;
    logic            accept;
    logic            cmpNe;
    logic            cmpLt;
    logic [PC_W-1:0] cmpPc;

    ////////////////////////////////////////////////////////////////////////////

    assign accept = issueValid && !st_q.busy
                    && (isCmpjReg(opcode) || isCmpjInd(opcode) || isClearAcc(opcode));

    cjx_cmp_branch u_cmp (
        .lhs       (operandData),
        .rhs       (st_q.imm),
        .pcBase    (st_q.pc),
        .relOffset (st_q.rel),
        .notEqual  (cmpNe),
        .lessThan  (cmpLt),
        .pcFinal   (cmpPc)
    );

    always_comb
    begin
        st_d          = st_q;
        st_d.done     = 1'b0;
        st_d.pcWrite  = 1'b0;
        st_d.accWrite = 1'b0;
        unique case (st_q.state)
            ST_IDLE:
            begin
                if (accept && isClearAcc(opcode))
                begin
                    st_d.done     = 1'b1;
                    st_d.accWrite = 1'b1;
                    st_d.acc      = ACC_CLEAR;
                    st_d.carry    = carryIn;
                    st_d.flags    = flagsIn;
                end
                else if (accept)
                begin
                    st_d.state   = ST_OPERAND;
                    st_d.busy    = 1'b1;
                    st_d.pc      = pcIn;
                    st_d.imm     = immData;
                    st_d.rel     = relOffset;
                    st_d.flags   = flagsIn;
                    st_d.opIsRam = isCmpjInd(opcode);
                    // register index or pointer index
                    st_d.opSel   = isCmpjInd(opcode) ? {2'b00, opcode[0]}
                                                     : opcode[SEL_W-1:0];
                end
            end
            ST_OPERAND:
            begin
                // operand arrives this cycle; second cycle ends the compare
                st_d.state   = ST_IDLE;
                st_d.busy    = 1'b0;
                st_d.done    = 1'b1;
                st_d.pcWrite = 1'b1;
                st_d.pc      = cmpPc;
                st_d.carry   = cmpLt;
                // no operand write strobe exists, accumulator untouched
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            st_q <= ST_RESET;
        else
            st_q <= st_d;
    end

    assign busy_q         = st_q.busy;
    assign done_q         = st_q.done;
    assign operandSel_q   = st_q.opSel;
    assign operandIsRam_q = st_q.opIsRam;
    assign pcWrite_q      = st_q.pcWrite;
    assign pcOut_q        = st_q.pc;
    assign accWrite_q     = st_q.accWrite;
    assign accOut_q       = st_q.acc;
    assign carryOut_q     = st_q.carry;
    assign flagsOut_q     = st_q.flags;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_regIssue;
        accept && isCmpjReg(opcode);
    endsequence

    sequence s_indIssue;
        accept && isCmpjInd(opcode);
    endsequence

    sequence s_clearIssue;
        accept && isClearAcc(opcode);
    endsequence

    sequence s_twoCycleDone;
        (busy_q && !done_q) ##1 (done_q && pcWrite_q && !busy_q);
    endsequence

    property p_reg_pc_equal;
        s_regIssue ##1 (operandData == $past(immData))
            |=> done_q && pcOut_q == PC_W'($past(pcIn, 2) + CMPJ_LEN);
    endproperty
    a_reg_pc_equal: assert property (p_reg_pc_equal)
        else $error("register compare equal: pc not advanced by three");

    property p_reg_branch;
        s_regIssue ##1 (operandData != $past(immData))
            |=> pcOut_q == PC_W'($past(pcIn, 2) + CMPJ_LEN + relExt($past(relOffset, 2)));
    endproperty
    a_reg_branch: assert property (p_reg_branch)
        else $error("register compare differ: wrong branch target");

    property p_reg_carry;
        s_regIssue ##1 1'b1
            |=> carryOut_q == ($past(operandData) < $past(immData, 2));
    endproperty
    a_reg_carry: assert property (p_reg_carry)
        else $error("register compare: carry does not reflect unsigned less-than");

    property p_reg_sel;
        s_regIssue |=> operandSel_q == $past(opcode[SEL_W-1:0]) && !operandIsRam_q
                       ##0 s_twoCycleDone;
    endproperty
    a_reg_sel: assert property (p_reg_sel)
        else $error("register compare: wrong select or not done in two cycles");

    property p_ind_sel;
        s_indIssue |=> operandIsRam_q && operandSel_q == {2'b00, $past(opcode[0])}
                       ##0 s_twoCycleDone;
    endproperty
    a_ind_sel: assert property (p_ind_sel)
        else $error("indirect compare: wrong pointer or not done in two cycles");

    property p_ind_result;
        s_indIssue ##1 1'b1
            |=> carryOut_q == ($past(operandData) < $past(immData, 2))
                && pcOut_q == PC_W'($past(pcIn, 2) + CMPJ_LEN
                                    + (($past(operandData) != $past(immData, 2)) ? relExt($past(relOffset, 2))
                                                                                 : PC_W'(0)));
    endproperty
    a_ind_result: assert property (p_ind_result)
        else $error("indirect compare: carry or branch decision wrong");

    property p_clear_acc;
        s_clearIssue |=> done_q && accWrite_q && accOut_q == ACC_CLEAR && !pcWrite_q && !busy_q;
    endproperty
    a_clear_acc: assert property (p_clear_acc)
        else $error("clear accumulator: not zero in one cycle");

    property p_clear_flags;
        s_clearIssue |=> carryOut_q == $past(carryIn) && flagsOut_q == $past(flagsIn);
    endproperty
    a_clear_flags: assert property (p_clear_flags)
        else $error("clear accumulator: flags changed");

    property p_cmpj_only_pc_carry;
        (s_regIssue or s_indIssue) |=> !accWrite_q
            ##1 (!accWrite_q && flagsOut_q == $past(flagsIn, 2) && accOut_q == $past(accOut_q, 2));
    endproperty
    a_cmpj_only_pc_carry: assert property (p_cmpj_only_pc_carry)
        else $error("compare touched accumulator or other flags");

endmodule

`default_nettype wire

//--- verification/testbench.sv
/*
 * Self-checking bench for the compare-and-jump and clear-accumulator execution.
 * Assumes cjx_exec as the block under test; the bench plays the core around it.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench
    import cjx_pkg::*;
;
    logic              clk            = 1'b0;
    logic              rstB           = 1'b0;
    logic              issueValid     = 1'b0;
    logic [7:0]        opcode         = 8'h00;
    logic [DATA_W-1:0] immData        = 8'h00;
    logic [DATA_W-1:0] relOffset      = 8'h00;
    logic [PC_W-1:0]   pcIn           = 16'h0000;
    logic              carryIn        = 1'b0;
    logic [FLAG_W-1:0] flagsIn        = 7'h00;
    logic [DATA_W-1:0] operandData    = 8'h00;
    logic              busy_q;
    logic              done_q;
    logic [SEL_W-1:0]  operandSel_q;
    logic              operandIsRam_q;
    logic              pcWrite_q;
    logic [PC_W-1:0]   pcOut_q;
    logic              accWrite_q;
    logic [DATA_W-1:0] accOut_q;
    logic              carryOut_q;
    logic [FLAG_W-1:0] flagsOut_q;
    int                nMismatch      = 0;
    int                numChecks      = 0;

    cjx_exec dut (
        .clk            (clk),
        .rst_b          (rstB),
        .issueValid     (issueValid),
        .opcode         (opcode),
        .immData        (immData),
        .relOffset      (relOffset),
        .pcIn           (pcIn),
        .carryIn        (carryIn),
        .flagsIn        (flagsIn),
        .operandData    (operandData),
        .busy_q         (busy_q),
        .done_q         (done_q),
        .operandSel_q   (operandSel_q),
        .operandIsRam_q (operandIsRam_q),
        .pcWrite_q      (pcWrite_q),
        .pcOut_q        (pcOut_q),
        .accWrite_q     (accWrite_q),
        .accOut_q       (accOut_q),
        .carryOut_q     (carryOut_q),
        .flagsOut_q     (flagsOut_q)
    );

    always #2.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic closeOut;
        if (nMismatch == 0 && numChecks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // compare-and-jump; busyIssue offers a clear while the compare is busy
    task automatic doCmp(input logic [7:0] opc, input logic [7:0] imm, input logic [7:0] rel,
                         input logic [15:0] pc, input logic [7:0] opd, input logic [6:0] flg,
                         input logic busyIssue);
        logic [15:0] pcExp;
        logic        ram;
        ram = (opc[7:1] == 7'h5B);
        pcExp = pc + 16'h0003 + ((opd != imm) ? {{8{rel[7]}}, rel} : 16'h0000);
        @(posedge clk);
        issueValid <= 1'b1;
        opcode <= opc;
        immData <= imm;
        relOffset <= rel;
        pcIn <= pc;
        flagsIn <= flg;
        carryIn <= ~(opd < imm);
        @(posedge clk);
        issueValid <= busyIssue;
        opcode <= busyIssue ? OPC_CLEAR_ACC : opc;
        flagsIn <= ~flg;
        operandData <= opd;
        #1;
        chk(busy_q, 1'b1);
        chk(done_q, 1'b0);
        chk(operandSel_q, ram ? {2'b00, opc[0]} : opc[2:0]);
        chk(operandIsRam_q, ram);
        @(posedge clk);
        issueValid <= 1'b0;
        operandData <= ~opd;
        #1;
        chk(done_q, 1'b1);
        chk(pcWrite_q, 1'b1);
        chk(accWrite_q, 1'b0);
        chk(pcOut_q, pcExp);
        chk(carryOut_q, opd < imm);
        chk(flagsOut_q, flg);
        @(posedge clk);
        #1;
        chk(done_q, 1'b0);
        chk(pcWrite_q, 1'b0);
    endtask

    // two clears back to back with different carry and flags
    task automatic doClear(input logic [6:0] f1, input logic [6:0] f2);
        @(posedge clk);
        issueValid <= 1'b1;
        opcode <= OPC_CLEAR_ACC;
        carryIn <= 1'b1;
        flagsIn <= f1;
        @(posedge clk);
        carryIn <= 1'b0;
        flagsIn <= f2;
        #1;
        chk({done_q, accWrite_q, pcWrite_q}, 3'b110);
        chk(accOut_q, 8'h00);
        chk({carryOut_q, flagsOut_q}, {1'b1, f1});
        @(posedge clk);
        issueValid <= 1'b0;
        #1;
        chk({done_q, accWrite_q, accOut_q}, 10'h300);
        chk({carryOut_q, flagsOut_q}, {1'b0, f2});
        @(posedge clk);
        #1;
        chk({done_q, accWrite_q}, 2'b00);
    endtask

    // opcodes outside the block draw no answer
    task automatic doNone(input logic [7:0] opc);
        @(posedge clk);
        issueValid <= 1'b1;
        opcode <= opc;
        @(posedge clk);
        issueValid <= 1'b0;
        repeat (2)
        begin
            #1;
            chk({busy_q, done_q}, 2'b00);
            @(posedge clk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge clk);
        rstB <= 1'b1;
        #1;
        chk({busy_q, done_q, pcWrite_q, pcOut_q, accOut_q}, 27'h0);
        for (int r = 0; r < 8; r++)
            doCmp(8'hB8 | r[7:0], 8'h60, r[0] ? 8'h80 : 8'h7F, 16'hFFFC + r[15:0],
                  (r % 3 == 0) ? 8'h60 : (r % 3 == 1) ? 8'h5F : 8'h61, r[6:0], r == 3);
        doCmp(8'hB6, 8'h00, 8'h05, 16'h2000, 8'hFF, 7'h55, 1'b1);
        doCmp(8'hB7, 8'hFF, 8'hFE, 16'h0001, 8'h00, 7'h2A, 1'b0);
        doCmp(8'hB7, 8'h42, 8'h10, 16'h3000, 8'h42, 7'h7F, 1'b0);
        doClear(7'h55, 7'h2A);
        doNone(8'hB4);
        doNone(8'hB5);
        doNone(8'hE5);
        closeOut();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        nMismatch++;
        closeOut();
    end
endmodule

`default_nettype wire
